// ---- logic/sdram_pin_device.sv ----
// Pin-level command decoder, burst engine and storage of a two-bank DRAM
`timescale 1ns/1ps
`include "sdram_consts.svh"
module sdram_pin_device
	import sdram_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Command pins from the controller
	input wire logic clk_gate_in,
	input wire pin_cmd_s cmd_in,
	input wire logic upper_byte_mask_in,
	input wire logic lower_byte_mask_in,
	// Shared data pins
	input wire logic [`DQ_W-1:0] data_in,
	output logic [`DQ_W-1:0] data_out,
	output logic [1:0] data_oe_out,
	// Avalon-MM register slave
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out
);

	dev_state_s st_ff;
	dev_state_s nxt_st;

	// Two banks of rows by columns, bank in the top index bit
	logic [`DQ_W-1:0] mem [0:(1 << `MEM_AW)-1];

	cmd_e cmd;
	logic [`COL_W-1:0] cur_col;
	logic [`MEM_AW-1:0] rd_idx;
	logic [`DQ_W-1:0] mem_rd;
	logic rd_live;
	logic src_v;
	logic [`DQ_W-1:0] src_d;
	logic [1:0] mem_we;
	logic [`MEM_AW-1:0] mem_wa;
	logic [`DQ_W-1:0] mem_wd;
	logic [1:0] keep_bytes;
	logic [`ROW_W-1:0] mword;
	logic [`COL_W-1:0] wr_last;
	logic page_run;

	function automatic cmd_e decode_cmd(input pin_cmd_s c);
		logic [2:0] s;
		s = {c.row_strobe_n, c.col_strobe_n, c.write_strobe_n};
		if (c.chip_sel_n) begin
			decode_cmd = CMD_NOP;
		end else begin
			case (s)
				3'h3: decode_cmd = CMD_ACT;
				3'h5: decode_cmd = CMD_RD;
				3'h4: decode_cmd = CMD_WR;
				3'h2: decode_cmd = CMD_PRE;
				3'h1: decode_cmd = CMD_REF;
				3'h0: decode_cmd = CMD_MODE;
				3'h6: decode_cmd = CMD_STOP;
				default: decode_cmd = CMD_NOP;
			endcase
		end
	endfunction

	function automatic mode_s mode_from_word(input logic [`ROW_W-1:0] w);
		mode_s m;
		m.bl = w[`MD_BL_LSB +: 3];
		m.interleave = w[`MD_IL_BIT];
		m.lat = w[`MD_LAT_LSB +: 3];
		m.single_write = w[`MD_SW_BIT];
		mode_from_word = m;
	endfunction

	function automatic logic [`ROW_W-1:0] mode_to_word(input mode_s m);
		logic [`ROW_W-1:0] w;
		w = '0;
		w[`MD_BL_LSB +: 3] = m.bl;
		w[`MD_IL_BIT] = m.interleave;
		w[`MD_LAT_LSB +: 3] = m.lat;
		w[`MD_SW_BIT] = m.single_write;
		mode_to_word = w;
	endfunction

	// Full page with interleave and unknown codes are refused whole
	function automatic logic mode_ok(input mode_s m);
		logic bl_ok;
		logic lat_ok;
		bl_ok = (m.bl == `BL_1) || (m.bl == `BL_2) || (m.bl == `BL_4) || (m.bl == `BL_8)
			|| ((m.bl == `BL_PAGE) && !m.interleave);
		lat_ok = (m.lat == `LAT_2) || (m.lat == `LAT_3);
		mode_ok = bl_ok && lat_ok;
	endfunction

	// Flat storage index of one cell, bank in the top bit
	function automatic logic [`MEM_AW-1:0] cell_addr(input logic b,
		input logic [`ROW_W-1:0] r, input logic [`COL_W-1:0] c);
		cell_addr = {b, r, c};
	endfunction

	// Reset image: banks closed, bus idle, default mode
	function automatic dev_state_s reset_state();
		dev_state_s s;
		s = '0;
		s.mode = mode_from_word(`MODE_RST);
		s.wait_req = 1'b1;
		reset_state = s;
	endfunction

	localparam dev_state_s RST_ST = reset_state();

	burst_col_gen u_col (
		.start_in(st_ff.start),
		.idx_in(st_ff.idx),
		.bl_in(st_ff.mode.bl),
		.interleave_in(st_ff.mode.interleave),
		.col_out(cur_col)
	);

	always_comb begin
		rd_idx = cell_addr(st_ff.bank, st_ff.row[st_ff.bank], cur_col);
		mem_rd = mem[rd_idx];
	end

	always_comb begin
		nxt_st = st_ff;
		cmd = decode_cmd(cmd_in);
		mem_we = 2'h0;
		mem_wa = '0;
		mem_wd = data_in;
		keep_bytes = ~{upper_byte_mask_in, lower_byte_mask_in};
		rd_live = st_ff.act && !st_ff.wr;
		src_v = 1'b0;
		src_d = '0;
		mword = mode_to_word(st_ff.mode);
		wr_last = st_ff.mode.single_write ? 8'h00 : bl_mask(st_ff.mode.bl);
		// Pipelined words already fetched still drive; masks guard them
		page_run = (st_ff.last == bl_mask(`BL_PAGE));

		// Register slave: one wait state, then the answer
		if (st_ff.wait_req && (avs_read_in || avs_write_in)) begin
			nxt_st.wait_req = 1'b0;
			// Writes leave the last read word in place
			if (avs_read_in) begin
				case (avs_address_in[3:2])
					`MODE_OFS: nxt_st.rdata = {21'h0, mword};
					`STATUS_OFS: nxt_st.rdata = {26'h0, st_ff.susp, st_ff.mode_err,
						st_ff.wr, st_ff.act, st_ff.open};
					`REFCNT_OFS: nxt_st.rdata = {16'h0, st_ff.refs};
					default: nxt_st.rdata = 32'h0;
				endcase
			end
		end else if (!st_ff.wait_req) begin
			nxt_st.wait_req = 1'b1;
			if (avs_write_in) begin
				case (avs_address_in[3:2])
					`MODE_OFS: begin
						if (avs_byteenable_in[0]) begin
							mword[7:0] = avs_writedata_in[7:0];
						end
						if (avs_byteenable_in[1]) begin
							mword[10:8] = avs_writedata_in[10:8];
						end
						if (mode_ok(mode_from_word(mword))) begin
							nxt_st.mode = mode_from_word(mword);
						end else begin
							nxt_st.mode_err = 1'b1;
						end
					end
					`STATUS_OFS: begin
						if (avs_byteenable_in[0] && avs_writedata_in[`ST_ERR_BIT]) begin
							nxt_st.mode_err = 1'b0;
						end
					end
					default: begin
					end
				endcase
			end
		end

		nxt_st.susp = !clk_gate_in;

		// A low clock gate freezes every pin-facing state bit
		if (clk_gate_in) begin
			// Read data path, one extra stage for latency three
			nxt_st.dv = rd_live;
			nxt_st.dd = mem_rd;
			if (st_ff.mode.lat == `LAT_3) begin
				src_v = st_ff.dv;
				src_d = st_ff.dd;
			end else begin
				src_v = rd_live;
				src_d = mem_rd;
			end
			// Masks stay live even with chip select high
			nxt_st.q = src_d;
			nxt_st.oe = src_v ? keep_bytes : 2'h0;

			// Burst engine step
			if (st_ff.act) begin
				if (st_ff.wr) begin
					mem_we = keep_bytes;
					mem_wa = rd_idx;
				end
				// Page bursts wrap in the row and stop only on a new command
				if ((st_ff.idx == st_ff.last) && !page_run) begin
					nxt_st.act = 1'b0;
					if (st_ff.apre) begin
						nxt_st.open[st_ff.bank] = 1'b0;
					end
				end else begin
					nxt_st.idx = st_ff.idx + 8'h01;
				end
			end

			case (cmd)
				CMD_ACT: begin
					if (!st_ff.open[cmd_in.bank_sel]) begin
						nxt_st.open[cmd_in.bank_sel] = 1'b1;
						nxt_st.row[cmd_in.bank_sel] = cmd_in.addr;
					end
				end
				CMD_RD, CMD_WR: begin
					if (st_ff.open[cmd_in.bank_sel]) begin
						nxt_st.bank = cmd_in.bank_sel;
						nxt_st.start = cmd_in.addr[`COL_W-1:0];
						nxt_st.apre = cmd_in.addr[`AUTO_PRE_BIT];
						nxt_st.wr = (cmd == CMD_WR);
						nxt_st.idx = 8'h00;
						nxt_st.act = 1'b1;
						nxt_st.last = bl_mask(st_ff.mode.bl);
						if (cmd == CMD_WR) begin
							// First word lands on the command edge itself
							mem_we = keep_bytes;
							mem_wa = cell_addr(cmd_in.bank_sel, st_ff.row[cmd_in.bank_sel],
								cmd_in.addr[`COL_W-1:0]);
							nxt_st.last = wr_last;
							nxt_st.idx = 8'h01;
							if (wr_last == 8'h00) begin
								nxt_st.act = 1'b0;
								if (cmd_in.addr[`AUTO_PRE_BIT]) begin
									nxt_st.open[cmd_in.bank_sel] = 1'b0;
								end
							end
						end
					end
				end
				CMD_PRE: begin
					nxt_st.act = 1'b0;
					if (cmd_in.addr[`AUTO_PRE_BIT]) begin
						nxt_st.open = 2'h0;
					end else begin
						nxt_st.open[cmd_in.bank_sel] = 1'b0;
					end
				end
				CMD_REF: begin
					// Only counted; the model array never decays
					nxt_st.refs = st_ff.refs + 16'h0001;
				end
				CMD_MODE: begin
					// Only legal with both banks closed; pins win over the bus
					if ((st_ff.open == 2'h0) && mode_ok(mode_from_word(cmd_in.addr))) begin
						nxt_st.mode = mode_from_word(cmd_in.addr);
					end else begin
						nxt_st.mode_err = 1'b1;
					end
				end
				CMD_STOP: begin
					// Halts the engine; words already in the pipe still drain
					nxt_st.act = 1'b0;
				end
				CMD_NOP: begin
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_ff <= RST_ST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Storage has no reset; contents are undefined after power-up
	always_ff @(posedge clk_in) begin
		if (mem_we[0]) begin
			mem[mem_wa][7:0] <= mem_wd[7:0];
		end
		if (mem_we[1]) begin
			mem[mem_wa][15:8] <= mem_wd[15:8];
		end
	end

	assign data_out = st_ff.q;
	assign data_oe_out = st_ff.oe;
	assign avs_readdata_out = st_ff.rdata;
	assign avs_waitrequest_out = st_ff.wait_req;

endmodule // sdram_pin_device

// ---- logic/sdram_consts.svh ----
// Constants for the two-bank synchronous DRAM pin interface
// Functional notes
// - All control, address and write data are sampled on the rising clock edge.
// - Read latency is programmable to 2 or 3 clock cycles.
// - Bursts of 1, 2, 4, 8 words or full page; full page only sequential.
// - Burst column order is sequential or interleaved by a wrap-type setting.
// - Two byte masks; masked byte is not driven on reads, not stored on writes.
// - Optional mode with burst reads but single-word writes.
// - Storage is two banks of 524,288 words of 16 bits each.
// - Clock gate high runs the device; low suspends it.
// - Chip select inactive ignores all inputs except clock, clock gate, masks; a running write burst still stores the data pins.
// - Row address latched when row strobe low; used by activate and precharge.
// - Column address latched when column strobe low, starting read or write.
// - Activate takes the row from address lines 0 to 10.
// - Read or write takes the column from address lines 0 to 7.
// - Address line 10 on read or write requests automatic precharge.
// - Precharge closes both banks with line 10 high, else the selected bank.
// - Bank select low activates the first bank, high the second.
// - Read and write data share 16 bidirectional pins.
// - Row strobe low, column and write strobe high decodes as activate.
// - All three strobes low decodes as mode set from the address lines.
`ifndef SDRAM_CONSTS_SVH
`define SDRAM_CONSTS_SVH

`define ROW_W 11
`define COL_W 8
`define DQ_W 16
`define MEM_AW 20
`define AUTO_PRE_BIT 10

`define MD_BL_LSB 0
`define MD_IL_BIT 3
`define MD_LAT_LSB 4
`define MD_SW_BIT 9

`define BL_1 3'h0
`define BL_2 3'h1
`define BL_4 3'h2
`define BL_8 3'h3
`define BL_PAGE 3'h7
`define LAT_2 3'h2
`define LAT_3 3'h3
`define MODE_RST 11'h030

`define MODE_OFS 2'h0
`define STATUS_OFS 2'h1
`define REFCNT_OFS 2'h2
`define ST_ERR_BIT 4

`endif

// ---- logic/sdram_pkg.sv ----
// Types shared by the DRAM pin interface modules
package sdram_pkg;
`include "sdram_consts.svh"

	typedef enum logic [2:0] {
		CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MODE, CMD_STOP
	} cmd_e;

	typedef struct packed {
		logic chip_sel_n;
		logic row_strobe_n;
		logic col_strobe_n;
		logic write_strobe_n;
		logic bank_sel;
		logic [`ROW_W-1:0] addr;
	} pin_cmd_s;

	typedef struct packed {
		logic single_write;
		logic [2:0] lat;
		logic interleave;
		logic [2:0] bl;
	} mode_s;

	typedef struct packed {
		mode_s mode;
		logic [1:0] open;
		logic [1:0][`ROW_W-1:0] row;
		logic act;
		logic wr;
		logic bank;
		logic apre;
		logic [`COL_W-1:0] start;
		logic [`COL_W-1:0] idx;
		logic [`COL_W-1:0] last;
		logic dv;
		logic [`DQ_W-1:0] dd;
		logic [`DQ_W-1:0] q;
		logic [1:0] oe;
		logic [15:0] refs;
		logic mode_err;
		logic susp;
		logic wait_req;
		logic [31:0] rdata;
	} dev_state_s;

	// Offset mask of a burst inside its column boundary
	function automatic logic [`COL_W-1:0] bl_mask(input logic [2:0] bl);
		case (bl)
			`BL_2: bl_mask = 8'h01;
			`BL_4: bl_mask = 8'h03;
			`BL_8: bl_mask = 8'h07;
			`BL_PAGE: bl_mask = 8'hFF;
			default: bl_mask = 8'h00;
		endcase
	endfunction
endpackage

// ---- logic/burst_col_gen.sv ----
// Column address of one word inside a burst
`timescale 1ns/1ps
`include "sdram_consts.svh"
module burst_col_gen
	import sdram_pkg::*;
(
	// Burst description
	input wire logic [`COL_W-1:0] start_in,
	input wire logic [`COL_W-1:0] idx_in,
	input wire logic [2:0] bl_in,
	input wire logic interleave_in,
	// Column of word idx_in
	output logic [`COL_W-1:0] col_out
);
	logic [`COL_W-1:0] m;
	logic [`COL_W-1:0] low;

	always_comb begin
		m = bl_mask(bl_in);
		// Upper bits stay fixed so the burst wraps inside its boundary
		low = interleave_in ? (start_in ^ idx_in) : (start_in + idx_in);
		col_out = (start_in & ~m) | (low & m);
	end
endmodule // burst_col_gen

// ---- tb/sdram_pin_device_checker.sv ----
// Concurrent checks on the DRAM pin device ports
`timescale 1ns/1ps
module sdram_pin_device_checker
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// Pin side
	input wire logic clk_gate_in,
	input wire logic upper_byte_mask_in,
	input wire logic lower_byte_mask_in,
	input wire logic [15:0] data_out,
	input wire logic [1:0] data_oe_out,
	// Register bus
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic avs_waitrequest_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	wire logic req = avs_read_in || avs_write_in;
	wire logic seen = req && avs_waitrequest_out;

	bus_answer_a: assert property (seen |=> !avs_waitrequest_out)
		else $error("bus answer late");
	bus_short_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("wait low too long");
	bus_idle_a: assert property (!req && avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("answer without request");
	unmapped_zero_a: assert property (seen && avs_read_in && avs_address_in[3:2] == 2'h3
		|=> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
	rdata_hold_a: assert property (!(avs_read_in && seen) |=> $stable(avs_readdata_out))
		else $error("read data changed");
	upper_mask_a: assert property (clk_gate_in && upper_byte_mask_in |=> !data_oe_out[1])
		else $error("upper byte driven while masked");
	lower_mask_a: assert property (clk_gate_in && lower_byte_mask_in |=> !data_oe_out[0])
		else $error("lower byte driven while masked");
	suspend_freeze_a: assert property (!clk_gate_in |=> $stable(data_out)
		&& $stable(data_oe_out)) else $error("pins moved while suspended");

	cover property (data_oe_out == 2'h3);
	cover property (data_oe_out == 2'h2);
	cover property (!clk_gate_in);
endmodule // sdram_pin_device_checker

bind sdram_pin_device sdram_pin_device_checker chk (.clk_in, .nrst_in, .clk_gate_in,
	.upper_byte_mask_in, .lower_byte_mask_in, .data_out, .data_oe_out, .avs_address_in,
	.avs_read_in, .avs_write_in, .avs_readdata_out, .avs_waitrequest_out);

// ---- tb/mem_ctrl_model.sv ----
// Controller model driving the DRAM command and write data pins
`timescale 1ns/1ps
module mem_ctrl_model
	import sdram_pkg::*;
#(
	parameter int POWER_UP_WAIT = 4000
)
(
	// Clock
	input wire logic clk_in,
	// Pins toward the device
	output pin_cmd_s cmd_out,
	output logic [15:0] dq_out
);
	initial begin
		cmd_out = '1;
		dq_out = 16'h0000;
	end
	// Code is {cs_n, ras_n, cas_n, we_n}, one command per edge
	task automatic op(input logic [3:0] c, input logic b, input logic [10:0] a,
		input logic [15:0] d);
		@(posedge clk_in);
		cmd_out <= {c, b, a};
		// Released bus flips so a stale word never looks valid
		dq_out <= c[0] ? ~dq_out : d;
	endtask
	// Wait 200 us, close both banks, set mode, eight refreshes
	task automatic init(input logic [10:0] mode);
		repeat (POWER_UP_WAIT) op(4'hF, 1'h0, 11'h000, 16'h0000);
		op(4'h2, 1'h0, 11'h400, 16'h0000);
		op(4'h0, 1'h0, mode, 16'h0000);
		repeat (8) op(4'h1, 1'h0, 11'h000, 16'h0000);
		// Idle pins, or the last refresh repeats on every edge
		op(4'hF, 1'h0, 11'h000, 16'h0000);
	endtask
	// Activate, then honour the activate_to_column_delay
	task automatic act(input logic b, input logic [10:0] row);
		op(4'h3, b, row, 16'h0000);
		repeat (2) op(4'hF, b, 11'h000, 16'h0000);
	endtask
endmodule // mem_ctrl_model

// ---- tb/sdram_pin_device_tb.sv ----
// Self-checking bench for the DRAM pin device
`timescale 1ns/1ps
module sdram_pin_device_tb
	import sdram_pkg::*;
;
	logic clk_in = 1'h0;
	logic nrst_in = 1'h0;
	logic gate = 1'h1;
	logic [1:0] mask = 2'h0;
	logic [3:0] adr = 4'h0;
	logic rd_en = 1'h0;
	logic wr_en = 1'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic bwait;
	pin_cmd_s cmd;
	logic [15:0] dq;
	logic [15:0] q;
	logic [1:0] oe;
	int failures = 0;
	int num_checks = 0;

	sdram_pin_device dut (.clk_in, .nrst_in, .clk_gate_in(gate), .cmd_in(cmd),
		.upper_byte_mask_in(mask[1]), .lower_byte_mask_in(mask[0]), .data_in(dq),
		.data_out(q), .data_oe_out(oe), .avs_address_in(adr), .avs_read_in(rd_en),
		.avs_write_in(wr_en), .avs_writedata_in(wdat), .avs_byteenable_in(4'hF),
		.avs_readdata_out(rdat), .avs_waitrequest_out(bwait));
	mem_ctrl_model ctl (.clk_in, .cmd_out(cmd), .dq_out(dq));

	initial begin
		forever #25 clk_in = ~clk_in;
	end

	task automatic test_done();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk_in);
		adr <= a;
		rd_en <= !wr;
		wr_en <= wr;
		wdat <= d;
		do @(posedge clk_in); while (bwait !== 1'h0);
		r = rdat;
		rd_en <= 1'h0;
		wr_en <= 1'h0;
	endtask

	function automatic logic [15:0] pat(input logic b, input logic [7:0] c);
		return {3'h5, b, 4'hA, c};
	endfunction

	// Word k of a burst stays inside its aligned block of n columns
	function automatic logic [7:0] col(input logic [7:0] s, input int k, input int n,
		input logic il);
		logic [7:0] m;
		m = 8'(n - 1);
		return (s & ~m) | ((il ? (s ^ 8'(k)) : (s + 8'(k))) & m);
	endfunction

	task automatic wr(input logic b, input logic [7:0] s, input int n);
		ctl.op(4'h4, b, {3'h0, s}, pat(b, s));
		for (int k = 1; k < n; k++)
			ctl.op(4'hE, b, 11'h000, pat(b, col(s, k, n, 1'h0)));
	endtask

	// Low ok means the command must leave the pins undriven
	task automatic rd(input logic [3:0] c, input logic b, input logic [10:0] a, input int lat,
		input int n, input logic il, input logic ok);
		logic [15:0] bm;
		bm = {{8{~mask[1]}}, {8{~mask[0]}}};
		ctl.op(c, b, a, 16'h0000);
		for (int i = 0; i < lat + n + 1; i++) begin
			ctl.op(4'hF, b, 11'h000, 16'h0000);
			@(negedge clk_in);
			if (ok && i >= lat - 1 && i < lat - 1 + n) begin
				chk(oe, 2'(~mask));
				chk(q & bm, pat(b, col(a[7:0], i - lat + 1, n, il)) & bm);
			end else
				chk(oe, 2'h0);
		end
	endtask

	task automatic t_regs();
		logic [31:0] r;
		bus(1'h0, 4'h0, 32'h0, r);
		chk(r, 32'h023);
		bus(1'h0, 4'h8, 32'h0, r);
		chk(r, 32'h8);
		bus(1'h1, 4'hC, 32'hFFFF, r);
		bus(1'h0, 4'hC, 32'h0, r);
		chk(r, 32'h0);
		bus(1'h1, 4'h0, 32'h005, r);
		bus(1'h0, 4'h4, 32'h0, r);
		chk(r[4], 1'h1);
		bus(1'h0, 4'h0, 32'h0, r);
		chk(r, 32'h023);
		bus(1'h1, 4'h4, 32'h10, r);
		bus(1'h0, 4'h4, 32'h0, r);
		chk(r, 32'h0);
	endtask

	task automatic t_seq();
		logic [31:0] r;
		ctl.act(1'h0, 11'h005);
		wr(1'h0, 8'h12, 8);
		rd(4'h5, 1'h0, 11'h012, 2, 8, 1'h0, 1'h1);
		@(posedge clk_in) mask <= 2'h1;
		rd(4'h5, 1'h0, 11'h014, 2, 8, 1'h0, 1'h1);
		@(posedge clk_in) mask <= 2'h0;
		rd(4'hD, 1'h0, 11'h010, 2, 8, 1'h0, 1'h0);
		@(posedge clk_in) gate <= 1'h0;
		bus(1'h0, 4'h4, 32'h0, r);
		chk(r, 32'h21);
		gate <= 1'h1;
		rd(4'h5, 1'h0, 11'h410, 2, 8, 1'h0, 1'h1);
		rd(4'h5, 1'h0, 11'h010, 2, 8, 1'h0, 1'h0);
	endtask

	task automatic t_il();
		ctl.op(4'h0, 1'h0, 11'h03B, 16'h0000);
		ctl.op(4'hF, 1'h0, 11'h000, 16'h0000);
		ctl.act(1'h0, 11'h005);
		rd(4'h5, 1'h0, 11'h012, 3, 8, 1'h1, 1'h1);
	endtask

	task automatic t_bank();
		ctl.op(4'h2, 1'h0, 11'h400, 16'h0000);
		ctl.op(4'h0, 1'h0, 11'h031, 16'h0000);
		ctl.op(4'hF, 1'h0, 11'h000, 16'h0000);
		ctl.act(1'h1, 11'h005);
		ctl.act(1'h0, 11'h005);
		wr(1'h1, 8'h04, 2);
		rd(4'h5, 1'h1, 11'h005, 3, 2, 1'h0, 1'h1);
		rd(4'h5, 1'h0, 11'h013, 3, 2, 1'h0, 1'h1);
		ctl.op(4'h2, 1'h1, 11'h000, 16'h0000);
		rd(4'h5, 1'h1, 11'h004, 3, 2, 1'h0, 1'h0);
		rd(4'h5, 1'h0, 11'h012, 3, 2, 1'h0, 1'h1);
	endtask

	// Single-write mode: burst words after the first must not land
	task automatic t_sw();
		ctl.op(4'h2, 1'h0, 11'h400, 16'h0000);
		ctl.op(4'h0, 1'h0, 11'h222, 16'h0000);
		ctl.op(4'hF, 1'h0, 11'h000, 16'h0000);
		ctl.act(1'h0, 11'h005);
		ctl.op(4'h4, 1'h0, 11'h010, pat(1'h0, 8'h10));
		repeat (3) ctl.op(4'hE, 1'h0, 11'h000, 16'hDEAD);
		rd(4'h5, 1'h0, 11'h010, 2, 4, 1'h0, 1'h1);
	endtask

	// Page burst runs past eight words until a burst stop
	task automatic t_page();
		ctl.op(4'h2, 1'h0, 11'h400, 16'h0000);
		ctl.op(4'h0, 1'h0, 11'h027, 16'h0000);
		ctl.op(4'hF, 1'h0, 11'h000, 16'h0000);
		ctl.act(1'h0, 11'h005);
		ctl.op(4'h5, 1'h0, 11'h010, 16'h0000);
		for (int i = 0; i < 14; i++) begin
			ctl.op((i == 10) ? 4'h6 : 4'hF, 1'h0, 11'h000, 16'h0000);
			@(negedge clk_in);
			if (i >= 1 && i <= 11)
				chk(oe, 2'h3);
			else
				chk(oe, 2'h0);
			if (i >= 1 && i <= 8)
				chk(q, pat(1'h0, 8'h10 + 8'(i - 1)));
		end
	endtask

	// Mid-run reset brings back the default mode and closed banks
	task automatic t_rst();
		logic [31:0] r;
		@(posedge clk_in) nrst_in <= 1'h0;
		@(posedge clk_in) nrst_in <= 1'h1;
		bus(1'h0, 4'h0, 32'h0, r);
		chk(r, 32'h030);
		bus(1'h0, 4'h4, 32'h0, r);
		chk(r, 32'h0);
	endtask

	initial begin
		repeat (4) @(posedge clk_in);
		nrst_in <= 1'h1;
		ctl.init(11'h023);
		t_regs();
		t_seq();
		t_il();
		t_bank();
		t_sw();
		t_page();
		t_rst();
		test_done();
	end

	// About two and a half times the expected run
	initial begin
		#500000;
		failures++;
		test_done();
	end
endmodule // sdram_pin_device_tb
